// ==== test/tb_top.sv ====
// bench: register map, field outputs, lookup and reset of the bank
// assumes: host model drives the register port
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        sreq = 1'b0;
	logic [1:0]  sch = 2'h0;
	logic        scs = 1'b0;
	logic [7:0]  addr;
	logic [23:0] wdata, rdata;
	logic        wr, rd, rvalid, hit, sval;
	logic [15:0] q1, k1, q2l, q2h, k2l, k2h, c0, sq, sc, sk;
	logic [7:0]  s3, s2, s1;
	logic [2:0]  scl, held;
	int          fail_count = 0;
	int          n_compared = 0;
	int          cycles = 0;
	logic [7:0]  ta [7] = '{8'hae, 8'haf, 8'hb0, 8'hb1, 8'hb2, 8'hb4, 8'hb5};
	logic [23:0] td [7] = '{24'ha1b2c3, 24'hd4e5f6, 24'h172839, 24'h4a5b6c,
		24'hff8e9f, 24'h030201, 24'hfffffd};
	logic [23:0] te [7] = '{24'ha1b2c3, 24'hd4e5f6, 24'h172839, 24'h4a5b6c,
		24'h008e9f, 24'h030201, 24'h000005};
	// lookup keys and expected picks
	logic [1:0]  lc [6] = '{2'h1, 2'h2, 2'h2, 2'h0, 2'h0, 2'h3};
	logic        ls [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
	logic [47:0] lx [6] = '{48'hb2c3_0000_a1d4, 48'he5f6_0000_174a,
		48'h2839_0000_8e9f, 48'h0000_5b6c_0000, 48'h0, 48'h0};
	logic [2:0]  lh [6] = '{3'h5, 3'h5, 3'h5, 3'h2, 3'h0, 3'h0};
	always #5 clk_i = ~clk_i;
	tpc_host_model host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata),
		.wr_o(wr), .rd_o(rd), .rdata_i(rdata), .rvalid_i(rvalid));
	tpc_coeff_regs DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .reg_hit_o(hit),
		.quadratic_coeff_highcur_ch1_o(q1), .quartic_coeff_highcur_ch1_o(k1),
		.quadratic_coeff_lowcur_ch2_o(q2l), .quadratic_coeff_highcur_ch2_o(q2h),
		.quartic_coeff_lowcur_ch2_o(k2l), .quartic_coeff_highcur_ch2_o(k2h),
		.cubic_coeff_highcur_ch0_o(c0), .ambient_segment_coeff_three_o(s3),
		.ambient_segment_coeff_two_o(s2), .ambient_segment_coeff_one_o(s1),
		.ambient_correction_scale_o(scl), .sel_req_i(sreq), .sel_ch_i(sch),
		.sel_curset_i(scs), .sel_valid_o(sval), .sel_quad_o(sq),
		.sel_cubic_o(sc), .sel_quartic_o(sk), .sel_held_o(held));
	// compare and count
	task automatic chk(input string n, input logic [47:0] s, input logic [47:0] e);
		n_compared++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask
	// verdict and end of run
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// hang guard
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			wrap_up();
		end
	end
	// main sequence
	initial begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			host.rd_reg(ta[i]);
			chk("reset value", {24'h0, host.rd_data}, 48'h0);
			chk("read valid", {47'h0, host.rd_ok}, 48'h1);
		end
		for (int i = 0; i < 7; i++) host.wr_reg(ta[i], td[i]);
		for (int i = 0; i < 7; i++) begin
			host.rd_reg(ta[i]);
			chk("readback", {24'h0, host.rd_data}, {24'h0, te[i]});
			chk("hit", {47'h0, hit}, 48'h1);
		end
		chk("quad ch1 high", {32'h0, q1}, 48'hb2c3);
		chk("quartic ch1", {32'h0, k1}, 48'ha1d4);
		chk("quad ch2 low", {32'h0, q2l}, 48'he5f6);
		chk("quad ch2 high", {32'h0, q2h}, 48'h2839);
		chk("quartic ch2 low", {32'h0, k2l}, 48'h174a);
		chk("cubic ch0", {32'h0, c0}, 48'h5b6c);
		chk("quartic ch2 high", {32'h0, k2h}, 48'h8e9f);
		chk("segments", {24'h0, s3, s2, s1}, 48'h030201);
		chk("scale", {45'h0, scl}, 48'h5);
		host.wr_reg(8'hb3, 24'hffffff);
		host.rd_reg(8'hb3);
		chk("unmapped data", {24'h0, host.rd_data}, 48'h0);
		chk("unmapped hit", {47'h0, hit}, 48'h0);
		host.rd_reg(8'hb4);
		chk("after unmapped", {24'h0, host.rd_data}, 48'h030201);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_i);
			sreq <= 1'b1;
			sch <= lc[i];
			scs <= ls[i];
			@(posedge clk_i);
			sreq <= 1'b0;
			// answer is sampled at the edge that ends its valid cycle
			@(posedge clk_i);
			chk("lookup valid", {47'h0, sval}, 48'h1);
			chk("lookup picks", {sq, sc, sk}, lx[i]);
			chk("lookup held", {45'h0, held}, {45'h0, lh[i]});
		end
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		@(posedge clk_i);
		chk("reset fields", {5'h0, k1, s3, s2, s1, scl}, 48'h0);
		chk("reset quads", {q1, q2l, q2h}, 48'h0);
		chk("reset lookup", {sq, sc, sk}, 48'h0);
		rst_n_i <= 1'b1;
		host.rd_reg(8'haf);
		chk("reset readback", {24'h0, host.rd_data}, 48'h0);
		wrap_up();
	end
endmodule // tb_top
bind tpc_coeff_regs tpc_coeff_regs_checker u_chk (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.reg_rvalid_o(reg_rvalid_o), .reg_hit_o(reg_hit_o),
	.quartic_coeff_highcur_ch1_o(quartic_coeff_highcur_ch1_o),
	.quadratic_coeff_lowcur_ch2_o(quadratic_coeff_lowcur_ch2_o),
	.quartic_coeff_lowcur_ch2_o(quartic_coeff_lowcur_ch2_o),
	.quartic_coeff_highcur_ch2_o(quartic_coeff_highcur_ch2_o),
	.cubic_coeff_highcur_ch0_o(cubic_coeff_highcur_ch0_o),
	.ambient_segment_coeff_three_o(ambient_segment_coeff_three_o),
	.ambient_correction_scale_o(ambient_correction_scale_o),
	.sel_req_i(sel_req_i), .sel_ch_i(sel_ch_i),
	.sel_curset_i(sel_curset_i), .sel_valid_o(sel_valid_o),
	.sel_quartic_o(sel_quartic_o));
`default_nettype wire

// ==== test/tpc_coeff_regs_checker.sv ====
// checker: write-to-field and read timing relations of the bank
// assumes: bound to tpc_coeff_regs, single clock domain
`default_nettype none
module tpc_coeff_regs_checker (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	// register port
	input wire logic [7:0]  reg_addr_i,
	input wire logic [23:0] reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [23:0] reg_rdata_o,
	input wire logic        reg_rvalid_o,
	input wire logic        reg_hit_o,
	// field outputs
	input wire logic [15:0] quartic_coeff_highcur_ch1_o,
	input wire logic [15:0] quadratic_coeff_lowcur_ch2_o,
	input wire logic [15:0] quartic_coeff_lowcur_ch2_o,
	input wire logic [15:0] quartic_coeff_highcur_ch2_o,
	input wire logic [15:0] cubic_coeff_highcur_ch0_o,
	input wire logic [7:0]  ambient_segment_coeff_three_o,
	input wire logic [2:0]  ambient_correction_scale_o,
	// engine lookup
	input wire logic        sel_req_i,
	input wire logic [1:0]  sel_ch_i,
	input wire logic        sel_curset_i,
	input wire logic        sel_valid_o,
	input wire logic [15:0] sel_quartic_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [23:0] wd_q;
	// write data one cycle back
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) wd_q <= 24'h000000;
		else wd_q <= reg_wdata_i;
	end
	// write decode per offset
	wire wr_ae = reg_wr_i && (reg_addr_i == 8'hae);
	wire wr_af = reg_wr_i && (reg_addr_i == 8'haf);
	wire wr_b0 = reg_wr_i && (reg_addr_i == 8'hb0);
	wire wr_b1 = reg_wr_i && (reg_addr_i == 8'hb1);
	wire wr_b2 = reg_wr_i && (reg_addr_i == 8'hb2);
	wire wr_b4 = reg_wr_i && (reg_addr_i == 8'hb4);
	wire wr_b5 = reg_wr_i && (reg_addr_i == 8'hb5);
	a_rvalid_pulse: assert property (
		reg_rvalid_o == $past(reg_rd_i))
		else $error("read valid not one cycle after strobe");
	a_split_ch1_hi: assert property (wr_ae |=>
		quartic_coeff_highcur_ch1_o[15:8] == wd_q[23:16])
		else $error("ch1 quartic high byte not taken");
	a_split_ch1_lo: assert property (wr_af |=>
		quartic_coeff_highcur_ch1_o[7:0] == wd_q[23:16])
		else $error("ch1 quartic low byte not taken");
	a_quad_lowcur: assert property (wr_af |=>
		quadratic_coeff_lowcur_ch2_o == wd_q[15:0])
		else $error("ch2 low quadratic not taken");
	a_split_ch2_hi: assert property (wr_b0 |=>
		quartic_coeff_lowcur_ch2_o[15:8] == wd_q[23:16])
		else $error("ch2 quartic high byte not taken");
	a_cubic_ch0: assert property (wr_b1 |=>
		cubic_coeff_highcur_ch0_o == wd_q[15:0] &&
		quartic_coeff_lowcur_ch2_o[7:0] == wd_q[23:16])
		else $error("0xb1 fields not taken");
	a_quartic_ch2: assert property (wr_b2 |=>
		quartic_coeff_highcur_ch2_o == wd_q[15:0])
		else $error("ch2 high quartic not taken");
	a_seg_three: assert property (wr_b4 |=>
		ambient_segment_coeff_three_o == wd_q[23:16])
		else $error("segment three not taken");
	a_scale_write: assert property (wr_b5 |=>
		ambient_correction_scale_o == wd_q[2:0])
		else $error("scale not taken");
	a_scale_hold: assert property (!wr_b5 |=>
		$stable(ambient_correction_scale_o))
		else $error("scale moved without write");
	a_unmapped_rd: assert property (
		reg_rd_i && reg_addr_i == 8'hb3 |=>
		!reg_hit_o && reg_rdata_o == 24'h000000)
		else $error("unmapped read not empty");
	a_sel_pulse: assert property (
		sel_valid_o == $past(sel_req_i))
		else $error("lookup valid not one cycle after request");
	a_sel_ch2_low: assert property (
		sel_req_i && sel_ch_i == 2'h2 && !sel_curset_i |=>
		sel_quartic_o == $past(quartic_coeff_lowcur_ch2_o))
		else $error("ch2 low lookup not the joined quartic");
	// main scenarios
	c_unmapped: cover property (reg_rd_i && reg_addr_i == 8'hb3);
	c_split_wr: cover property (wr_b0 ##1 1'b1 ##[1:8] wr_b1);
	c_scale_wr: cover property (wr_b5);
	c_lookup: cover property (sel_req_i && sel_ch_i == 2'h2);
endmodule // tpc_coeff_regs_checker
`default_nettype wire

// ==== test/tpc_host_model.sv ====
// host model: drives the register port, one strobe per access
// assumes: shares clk_i with the bank; tasks called from tb_top
`default_nettype none
module tpc_host_model (
	// clock
	input  wire logic        clk_i,
	// register port
	output logic      [7:0]  addr_o,
	output logic      [23:0] wdata_o,
	output logic             wr_o,
	output logic             rd_o,
	input  wire logic [23:0] rdata_i,
	input  wire logic        rvalid_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0] rd_data;
	logic        rd_ok;
	// port idle at time zero
	initial begin
		addr_o = 8'h00;
		wdata_o = 24'h000000;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// write; reserved fields zeroed, released lines inverted
	task automatic wr_reg(input logic [7:0] a, input logic [23:0] d);
		logic [23:0] v;
		v = d;
		if (a == 8'hb2) v[23:16] = 8'h00;
		if (a == 8'hb5) v[23:3] = 21'h000000;
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= v;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~v;
	endtask
	// read; data taken at the edge where the valid pulse is sampled
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(posedge clk_i);
		rd_ok = rvalid_i;
		rd_data = rdata_i;
	endtask
endmodule // tpc_host_model
`default_nettype wire

// ==== verilog/tpc_coeff_regs.sv ====
// tpc_coeff_regs: 24-bit read/write coefficient registers for the
// phase-correction engine, with a lookup port for the engine.
// assumes: register port is the internal side of the serial control
// interface, synchronous to clk_i, one access per strobe.
`default_nettype none

module tpc_coeff_regs (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// register port
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [23:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [23:0] reg_rdata_o,
	output logic             reg_rvalid_o,
	output logic             reg_hit_o,
	// coefficients to the correction engine
	output logic      [15:0] quadratic_coeff_highcur_ch1_o,
	output logic      [15:0] quartic_coeff_highcur_ch1_o,
	output logic      [15:0] quadratic_coeff_lowcur_ch2_o,
	output logic      [15:0] quadratic_coeff_highcur_ch2_o,
	output logic      [15:0] quartic_coeff_lowcur_ch2_o,
	output logic      [15:0] quartic_coeff_highcur_ch2_o,
	output logic      [15:0] cubic_coeff_highcur_ch0_o,
	output logic      [7:0]  ambient_segment_coeff_three_o,
	output logic      [7:0]  ambient_segment_coeff_two_o,
	output logic      [7:0]  ambient_segment_coeff_one_o,
	output logic      [2:0]  ambient_correction_scale_o,
	// engine lookup by channel and current set
	input  wire logic        sel_req_i,
	input  wire logic [1:0]  sel_ch_i,
	input  wire logic        sel_curset_i,
	output logic             sel_valid_o,
	output logic      [15:0] sel_quad_o,
	output logic      [15:0] sel_cubic_o,
	output logic      [15:0] sel_quartic_o,
	output logic      [2:0]  sel_held_o
);

	// address match, used by every write enable and the read mux
	function automatic logic addr_hit(input logic [7:0] a,
		input logic [7:0] off);
		addr_hit = (a == off);
	endfunction

	// field storage
	logic [7:0]  quartic_hi_ch1_r;
	logic [15:0] quad_highcur_ch1_r;
	logic [7:0]  quartic_lo_ch1_r;
	logic [15:0] quad_lowcur_ch2_r;
	logic [7:0]  quartic_hi_lowcur_ch2_r;
	logic [15:0] quad_highcur_ch2_r;
	logic [7:0]  quartic_lo_lowcur_ch2_r;
	logic [15:0] cubic_highcur_ch0_r;
	logic [15:0] quartic_highcur_ch2_r;
	logic [7:0]  seg_three_r;
	logic [7:0]  seg_two_r;
	logic [7:0]  seg_one_r;
	logic [2:0]  scale_r;

	// read and lookup registers
	logic [23:0] rdata_r;
	logic [23:0] rdata_nxt;
	logic        rvalid_r;
	logic        hit_r;
	logic        sel_valid_r;
	logic [15:0] sel_quad_r;
	logic [15:0] sel_cubic_r;
	logic [15:0] sel_quartic_r;
	logic [2:0]  sel_held_r;

	// decode wires
	wire logic       hit_ae;
	wire logic       hit_af;
	wire logic       hit_b0;
	wire logic       hit_b1;
	wire logic       hit_b2;
	wire logic       hit_b4;
	wire logic       hit_b5;
	wire logic       hit_any;
	wire logic [7:0] wr_upper;
	wire logic [15:0] wr_coef;

	// combined split coefficients
	wire logic [15:0] quartic_highcur_ch1;
	wire logic [15:0] quartic_lowcur_ch2;

	// lookup results
	wire logic [15:0] pick_quad;
	wire logic [15:0] pick_cubic;
	wire logic [15:0] pick_quartic;
	wire logic [2:0]  pick_held;

	// address decode of the bank
	assign hit_ae = addr_hit(reg_addr_i, tpc_pkg::OFF_QUARTIC_HI_CH1);
	assign hit_af = addr_hit(reg_addr_i,
		tpc_pkg::OFF_TX1_QUARTIC_LO_TX2_QUAD_LOWCUR);
	assign hit_b0 = addr_hit(reg_addr_i,
		tpc_pkg::OFF_TX2_QUARTIC_HI_QUAD_HIGHCUR);
	assign hit_b1 = addr_hit(reg_addr_i,
		tpc_pkg::OFF_TX2_QUARTIC_LO_TX0_CUBIC);
	assign hit_b2 = addr_hit(reg_addr_i, tpc_pkg::OFF_TX2_QUARTIC_HIGHCUR);
	assign hit_b4 = addr_hit(reg_addr_i,
		tpc_pkg::OFF_AMBIENT_PWL_SEGMENT_COEFFS);
	assign hit_b5 = addr_hit(reg_addr_i, tpc_pkg::OFF_AMBIENT_PWL_SCALE);
	assign hit_any = hit_ae | hit_af | hit_b0 | hit_b1 | hit_b2 | hit_b4
		| hit_b5;

	// common field slices of the write word
	assign wr_upper = reg_wdata_i[tpc_pkg::POS_UPPER_BYTE +: 8];
	assign wr_coef  = reg_wdata_i[tpc_pkg::POS_COEF16 +: 16];

	// high byte above, low byte below
	assign quartic_highcur_ch1 = {quartic_hi_ch1_r,
		quartic_lo_ch1_r};
	assign quartic_lowcur_ch2 = {quartic_hi_lowcur_ch2_r,
		quartic_lo_lowcur_ch2_r};

	// register 0xae: quartic high byte ch1, quadratic ch1 high current
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			quartic_hi_ch1_r   <= tpc_pkg::RST_BYTE;
			quad_highcur_ch1_r <= tpc_pkg::RST_COEF;
		end else if (reg_wr_i && hit_ae) begin
			quartic_hi_ch1_r   <= wr_upper;
			quad_highcur_ch1_r <= wr_coef;
		end
	end

	// register 0xaf: quartic low byte ch1, quadratic ch2 low current
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			quartic_lo_ch1_r  <= tpc_pkg::RST_BYTE;
			quad_lowcur_ch2_r <= tpc_pkg::RST_COEF;
		end else if (reg_wr_i && hit_af) begin
			quartic_lo_ch1_r  <= wr_upper;
			quad_lowcur_ch2_r <= wr_coef;
		end
	end

	// register 0xb0: quartic high byte ch2 low, quadratic ch2 high
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			quartic_hi_lowcur_ch2_r <= tpc_pkg::RST_BYTE;
			quad_highcur_ch2_r      <= tpc_pkg::RST_COEF;
		end else if (reg_wr_i && hit_b0) begin
			quartic_hi_lowcur_ch2_r <= wr_upper;
			quad_highcur_ch2_r      <= wr_coef;
		end
	end

	// register 0xb1: quartic low byte ch2 low, cubic ch0 high
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			quartic_lo_lowcur_ch2_r <= tpc_pkg::RST_BYTE;
			cubic_highcur_ch0_r     <= tpc_pkg::RST_COEF;
		end else if (reg_wr_i && hit_b1) begin
			quartic_lo_lowcur_ch2_r <= wr_upper;
			cubic_highcur_ch0_r     <= wr_coef;
		end
	end

	// register 0xb2: quartic ch2 high; upper byte is reserved, not kept
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			quartic_highcur_ch2_r <= tpc_pkg::RST_COEF;
		end else if (reg_wr_i && hit_b2) begin
			quartic_highcur_ch2_r <= wr_coef;
		end
	end

	// register 0xb4: ambient segment coefficients
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			seg_three_r <= tpc_pkg::RST_BYTE;
			seg_two_r   <= tpc_pkg::RST_BYTE;
			seg_one_r   <= tpc_pkg::RST_BYTE;
		end else if (reg_wr_i && hit_b4) begin
			seg_three_r <= reg_wdata_i[tpc_pkg::POS_SEG_THREE +: 8];
			seg_two_r   <= reg_wdata_i[tpc_pkg::POS_SEG_TWO +: 8];
			seg_one_r   <= reg_wdata_i[tpc_pkg::POS_SEG_ONE +: 8];
		end
	end

	// register 0xb5: scale factor; bits 23:3 reserved, not kept
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scale_r <= tpc_pkg::RST_SCALE;
		end else if (reg_wr_i && hit_b5) begin
			scale_r <= reg_wdata_i[tpc_pkg::POS_SCALE +: 3];
		end
	end

	// read word assembly; reserved bits and unmapped offsets read zero
	always_comb begin
		rdata_nxt = tpc_pkg::RST_WORD;
		if (hit_ae) begin
			rdata_nxt = {quartic_hi_ch1_r, quad_highcur_ch1_r};
		end else if (hit_af) begin
			rdata_nxt = {quartic_lo_ch1_r, quad_lowcur_ch2_r};
		end else if (hit_b0) begin
			rdata_nxt = {quartic_hi_lowcur_ch2_r, quad_highcur_ch2_r};
		end else if (hit_b1) begin
			rdata_nxt = {quartic_lo_lowcur_ch2_r, cubic_highcur_ch0_r};
		end else if (hit_b2) begin
			rdata_nxt = {tpc_pkg::RST_BYTE, quartic_highcur_ch2_r};
		end else if (hit_b4) begin
			rdata_nxt = {seg_three_r, seg_two_r, seg_one_r};
		end else if (hit_b5) begin
			rdata_nxt = {21'h000000, scale_r};
		end
	end

	// read answer one cycle after the strobe; data stands until next read
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_r  <= tpc_pkg::RST_WORD;
			rvalid_r <= 1'b0;
			hit_r    <= 1'b0;
		end else begin
			rvalid_r <= reg_rd_i;
			if (reg_rd_i) begin
				rdata_r <= rdata_nxt;
				hit_r   <= hit_any;
			end
		end
	end

	// coefficient lookup for the engine
	tpc_coeff_select u_select (
		.ch_i                  (sel_ch_i),
		.curset_i              (sel_curset_i),
		.quad_highcur_ch1_i    (quad_highcur_ch1_r),
		.quartic_highcur_ch1_i (quartic_highcur_ch1),
		.quad_lowcur_ch2_i     (quad_lowcur_ch2_r),
		.quad_highcur_ch2_i    (quad_highcur_ch2_r),
		.quartic_lowcur_ch2_i  (quartic_lowcur_ch2),
		.quartic_highcur_ch2_i (quartic_highcur_ch2_r),
		.cubic_highcur_ch0_i   (cubic_highcur_ch0_r),
		.quad_o                (pick_quad),
		.cubic_o               (pick_cubic),
		.quartic_o             (pick_quartic),
		.held_o                (pick_held)
	);

	// lookup answer registered; stands until the next request
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sel_valid_r   <= 1'b0;
			sel_quad_r    <= tpc_pkg::RST_COEF;
			sel_cubic_r   <= tpc_pkg::RST_COEF;
			sel_quartic_r <= tpc_pkg::RST_COEF;
			sel_held_r    <= 3'h0;
		end else begin
			sel_valid_r <= sel_req_i;
			if (sel_req_i) begin
				sel_quad_r    <= pick_quad;
				sel_cubic_r   <= pick_cubic;
				sel_quartic_r <= pick_quartic;
				sel_held_r    <= pick_held;
			end
		end
	end

	// outputs, each straight from flip-flops
	assign reg_rdata_o  = rdata_r;
	assign reg_rvalid_o = rvalid_r;
	assign reg_hit_o    = hit_r;
	assign quadratic_coeff_highcur_ch1_o = quad_highcur_ch1_r;
	assign quartic_coeff_highcur_ch1_o   = quartic_highcur_ch1;
	assign quadratic_coeff_lowcur_ch2_o  = quad_lowcur_ch2_r;
	assign quadratic_coeff_highcur_ch2_o = quad_highcur_ch2_r;
	assign quartic_coeff_lowcur_ch2_o    = quartic_lowcur_ch2;
	assign quartic_coeff_highcur_ch2_o   = quartic_highcur_ch2_r;
	assign cubic_coeff_highcur_ch0_o     = cubic_highcur_ch0_r;
	assign ambient_segment_coeff_three_o = seg_three_r;
	assign ambient_segment_coeff_two_o   = seg_two_r;
	assign ambient_segment_coeff_one_o   = seg_one_r;
	assign ambient_correction_scale_o    = scale_r;
	assign sel_valid_o   = sel_valid_r;
	assign sel_quad_o    = sel_quad_r;
	assign sel_cubic_o   = sel_cubic_r;
	assign sel_quartic_o = sel_quartic_r;
	assign sel_held_o    = sel_held_r;

endmodule // tpc_coeff_regs

`default_nettype wire

// ==== verilog/tpc_coeff_select.sv ====
// tpc_coeff_select: picks the nonlinearity coefficients that belong to
// one transmit channel and drive current set.
// assumes: pure combinational, results registered by the caller.
`default_nettype none

module tpc_coeff_select (
	// lookup key
	input  wire logic [1:0]  ch_i,
	input  wire logic        curset_i,
	// stored coefficients
	input  wire logic [15:0] quad_highcur_ch1_i,
	input  wire logic [15:0] quartic_highcur_ch1_i,
	input  wire logic [15:0] quad_lowcur_ch2_i,
	input  wire logic [15:0] quad_highcur_ch2_i,
	input  wire logic [15:0] quartic_lowcur_ch2_i,
	input  wire logic [15:0] quartic_highcur_ch2_i,
	input  wire logic [15:0] cubic_highcur_ch0_i,
	// picked values and which of them this bank holds
	output logic      [15:0] quad_o,
	output logic      [15:0] cubic_o,
	output logic      [15:0] quartic_o,
	output logic      [2:0]  held_o
);

	// key decode
	wire logic is_high;
	wire logic k_ch0_hi;
	wire logic k_ch1_hi;
	wire logic k_ch2_lo;
	wire logic k_ch2_hi;

	// low set on low current, high set on high current
	assign is_high  = (curset_i == tpc_pkg::HIGH_CURRENT_SET);
	assign k_ch0_hi = (ch_i == tpc_pkg::CH0) && is_high;
	assign k_ch1_hi = (ch_i == tpc_pkg::CH1) && is_high;
	assign k_ch2_lo = (ch_i == tpc_pkg::CH2) && !is_high;
	assign k_ch2_hi = (ch_i == tpc_pkg::CH2) && is_high;

	// second order
	assign quad_o = k_ch1_hi ? quad_highcur_ch1_i :
		k_ch2_lo ? quad_lowcur_ch2_i :
		k_ch2_hi ? quad_highcur_ch2_i : tpc_pkg::RST_COEF;

	// third order
	assign cubic_o = k_ch0_hi ? cubic_highcur_ch0_i : tpc_pkg::RST_COEF;

	// fourth order
	assign quartic_o = k_ch1_hi ? quartic_highcur_ch1_i :
		k_ch2_lo ? quartic_lowcur_ch2_i :
		k_ch2_hi ? quartic_highcur_ch2_i : tpc_pkg::RST_COEF;

	// bit0 quad, bit1 cubic, bit2 quartic
	assign held_o = {k_ch1_hi | k_ch2_lo | k_ch2_hi, k_ch0_hi,
		k_ch1_hi | k_ch2_lo | k_ch2_hi};

endmodule // tpc_coeff_select

`default_nettype wire

// ==== verilog/tpc_pkg.sv ====
// tpc_pkg: register map, field layout and reset values of the
// phase-calibration coefficient bank.
// assumes: included in compile order before every design file.
`default_nettype none

package tpc_pkg;

	// register word and address widths
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 24;
	localparam int unsigned COEF_W = 16;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned SCALE_W = 3;

	// register offsets
	localparam logic [7:0] OFF_QUARTIC_HI_CH1 = 8'hae;
	localparam logic [7:0] OFF_TX1_QUARTIC_LO_TX2_QUAD_LOWCUR = 8'haf;
	localparam logic [7:0] OFF_TX2_QUARTIC_HI_QUAD_HIGHCUR = 8'hb0;
	localparam logic [7:0] OFF_TX2_QUARTIC_LO_TX0_CUBIC = 8'hb1;
	localparam logic [7:0] OFF_TX2_QUARTIC_HIGHCUR = 8'hb2;
	localparam logic [7:0] OFF_AMBIENT_PWL_SEGMENT_COEFFS = 8'hb4;
	localparam logic [7:0] OFF_AMBIENT_PWL_SCALE = 8'hb5;

	// field positions (lsb of each field)
	localparam int unsigned POS_UPPER_BYTE = 16;
	localparam int unsigned POS_COEF16 = 0;
	localparam int unsigned POS_SEG_THREE = 16;
	localparam int unsigned POS_SEG_TWO = 8;
	localparam int unsigned POS_SEG_ONE = 0;
	localparam int unsigned POS_SCALE = 0;

	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_COEF = 16'h0000;
	localparam logic [2:0] RST_SCALE = 3'h0;
	localparam logic [23:0] RST_WORD = 24'h000000;

	// transmit channel codes
	localparam logic [1:0] CH0 = 2'h0;
	localparam logic [1:0] CH1 = 2'h1;
	localparam logic [1:0] CH2 = 2'h2;

	// drive current set selection
	typedef enum logic {
		LOW_CURRENT_SET  = 1'b0,
		HIGH_CURRENT_SET = 1'b1
	} tpc_curset_e;

endpackage : tpc_pkg

`default_nettype wire
